//--- hw/mrab_pkg.sv
// Package for the metering register access bridge.
// Holds the register offsets, field positions, reset values and timing counts.
package mrab_pkg;
    // Special-function register offsets.
    localparam logic [7:0] OFS_POINTER = 8'h91;
    localparam logic [7:0] OFS_DATA_LOW = 8'h92;
    localparam logic [7:0] OFS_DATA_MID = 8'h93;
    localparam logic [7:0] OFS_DATA_HIGH = 8'h94;
    localparam logic [7:0] OFS_VRMS_LOW = 8'hD1;
    localparam logic [7:0] OFS_VRMS_MID = 8'hD2;
    localparam logic [7:0] OFS_VRMS_HIGH = 8'hD3;
    localparam logic [7:0] OFS_IRMS_LOW = 8'hD4;
    localparam logic [7:0] OFS_IRMS_MID = 8'hD5;
    localparam logic [7:0] OFS_IRMS_HIGH = 8'hD6;
    localparam logic [7:0] OFS_IRQ_EN_LOW = 8'hD9;
    localparam logic [7:0] OFS_IRQ_EN_MID = 8'hDA;
    localparam logic [7:0] OFS_IRQ_EN_HIGH = 8'hDB;
    localparam logic [7:0] OFS_IRQ_ST_LOW = 8'hDC;
    localparam logic [7:0] OFS_IRQ_ST_MID = 8'hDD;
    localparam logic [7:0] OFS_IRQ_ST_HIGH = 8'hDE;
    localparam logic [7:0] OFS_WAV1_LOW = 8'hE2;
    localparam logic [7:0] OFS_WAV1_MID = 8'hE3;
    localparam logic [7:0] OFS_WAV1_HIGH = 8'hE4;
    localparam logic [7:0] OFS_WAV2_LOW = 8'hE5;
    localparam logic [7:0] OFS_WAV2_MID = 8'hE6;
    localparam logic [7:0] OFS_WAV2_HIGH = 8'hE7;

    // Pointer fields.
    localparam int PTR_DIR_BIT = 7;
    localparam int PTR_ADDR_MSB = 6;

    // Reset values.
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [23:0] RST_WORD = 24'h000000;

    // Timing: system clock and metering clock rates in hertz.
    localparam int SYS_CLK_HZ = 100000000;
    localparam int SRC_CLK_HZ = 4096000;
    localparam int METER_DIV = 5;
    localparam int METER_CLK_HZ = SRC_CLK_HZ / METER_DIV;
    localparam int METER_TICK_CYCLES = SYS_CLK_HZ / METER_CLK_HZ;

    typedef enum logic [1:0] {
        MRAB_IDLE = 2'b00,
        MRAB_PEND = 2'b01
    } mrab_state_type;
endpackage : mrab_pkg

//--- hw/mrab_tick_div.sv
// Divider that turns the system clock into a one-cycle enable pulse.
// Assumes a single synchronous clock and active-low synchronous reset.
`timescale 1ns/1ps
module mrab_tick_div #(
    parameter int PERIOD = 122
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_n,
    // Enable pulse, one cycle every PERIOD cycles.
    output logic tick
);
    localparam int CW = $clog2(PERIOD + 1);
    localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);
    logic [CW-1:0] cnt_r;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cnt_r <= '0;
            tick <= 1'b0;
        end else begin
            tick <= (cnt_r == LAST);
            cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + CW'(1);
        end
    end
endmodule : mrab_tick_div

//--- hw/mrab_bridge.sv
// Bridge from the processor's special-function register bus to the metering core.
// Assumes the metering core logic runs on sys_clk, gated by the metering tick.
//
// How it works
// - Rms, interrupt and waveform bytes are direct registers; others go through the pointer.
// - Each interrupt status byte is captured from the core when that byte is read.
// - Waveform and rms values are 24 bits, shown as low, middle and high bytes.
// - Reading a high byte snapshots all 24 bits in that same access.
// - Low and middle reads return the last snapshot; read the high byte first.
// - The pointer sits at 0x91; writing it starts an indirect access.
// - Pointer bit 7 is direction, 1 write and 0 read; bits 6..0 are address.
// - An indirect write copies the three data bytes into the addressed register.
// - A one-byte target takes only the low data byte on a write.
// - The metering side steps at 4.096 MHz divided by five, 819.2 kHz.
// - Indirect requests are synchronised to the metering rate for a 100 MHz processor clock only.
// - An indirect read copies the addressed register into the three data bytes.
// - A one-byte read updates the low byte and clears middle and high bytes.
`timescale 1ns/1ps
module mrab_bridge (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_n,
    // Special-function register bus.
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // Live values from the metering core.
    input wire logic [23:0] voltage_rms_bytes,
    input wire logic [23:0] current_rms_bytes,
    input wire logic [23:0] waveform_sample_one,
    input wire logic [23:0] waveform_sample_two,
    input wire logic [23:0] irq_status_live,
    // Interrupt enable and status write-back to the core.
    output logic [23:0] metering_interrupt_enable,
    output logic irq_status_wr,
    output logic [1:0] irq_status_byte,
    output logic [7:0] irq_status_wdata,
    // Indirect internal register port, stepped by the metering tick.
    output logic meter_tick,
    output logic [6:0] mreg_addr,
    output logic mreg_wr,
    output logic mreg_rd,
    output logic [23:0] mreg_wdata,
    input wire logic [23:0] mreg_rdata,
    input wire logic mreg_one_byte,
    // Indirect access still in flight.
    output logic pointer_busy
);
    import mrab_pkg::*;

    mrab_state_type state_r;
    logic [7:0] metering_pointer_address_r;
    logic [7:0] pointer_data_low_r;
    logic [7:0] pointer_data_middle_r;
    logic [7:0] pointer_data_high_r;
    logic [23:0] vrms_snap_r;
    logic [23:0] irms_snap_r;
    logic [23:0] wav1_snap_r;
    logic [23:0] wav2_snap_r;
    logic [7:0] rdata_nxt;
    logic ptr_wr;
    logic done;

    // The divider is the metering clock; the core acts only on its pulse.
    mrab_tick_div #(
        .PERIOD(METER_TICK_CYCLES)
    ) u_div (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .tick(meter_tick)
    );

    assign ptr_wr = sfr_wr && (sfr_addr == OFS_POINTER);
    assign done = (state_r == MRAB_PEND) && meter_tick;
    assign pointer_busy = (state_r == MRAB_PEND);

    // A pointer write while one is pending replaces it; the core sees one access only.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_r <= MRAB_IDLE;
        end else begin
            case (state_r)
                MRAB_IDLE: begin
                    if (ptr_wr) begin
                        state_r <= MRAB_PEND;
                    end
                end
                MRAB_PEND: begin
                    if (done && !ptr_wr) begin
                        state_r <= MRAB_IDLE;
                    end
                end
                default: begin
                    state_r <= MRAB_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            metering_pointer_address_r <= RST_BYTE;
        end else if (ptr_wr) begin
            metering_pointer_address_r <= sfr_wdata;
        end
    end

    // Pulses to the core land only in the cycle after a metering tick.
    // The address follows the pointer at once, so the core has flagged a one-byte
    // target well before the write data is latched on the tick.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            mreg_wr <= 1'b0;
            mreg_rd <= 1'b0;
            mreg_addr <= 7'h00;
            mreg_wdata <= RST_WORD;
        end else begin
            mreg_wr <= done && !ptr_wr && metering_pointer_address_r[PTR_DIR_BIT];
            mreg_rd <= done && !ptr_wr && !metering_pointer_address_r[PTR_DIR_BIT];
            if (ptr_wr) begin
                mreg_addr <= sfr_wdata[PTR_ADDR_MSB:0];
            end
            if (done && !ptr_wr) begin
                mreg_wdata[7:0] <= pointer_data_low_r;
                mreg_wdata[15:8] <= mreg_one_byte ? RST_BYTE : pointer_data_middle_r;
                mreg_wdata[23:16] <= mreg_one_byte ? RST_BYTE : pointer_data_high_r;
            end
        end
    end

    // The core holds mreg_rdata for mreg_addr in the same cycle as the read request.
    logic rd_cap_r;
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rd_cap_r <= 1'b0;
        end else begin
            rd_cap_r <= done && !ptr_wr && !metering_pointer_address_r[PTR_DIR_BIT];
        end
    end

    // Read capture wins over a processor write in the same cycle.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pointer_data_low_r <= RST_BYTE;
            pointer_data_middle_r <= RST_BYTE;
            pointer_data_high_r <= RST_BYTE;
        end else if (rd_cap_r) begin
            pointer_data_low_r <= mreg_rdata[7:0];
            pointer_data_middle_r <= mreg_one_byte ? RST_BYTE : mreg_rdata[15:8];
            pointer_data_high_r <= mreg_one_byte ? RST_BYTE : mreg_rdata[23:16];
        end else if (sfr_wr) begin
            if (sfr_addr == OFS_DATA_LOW) begin
                pointer_data_low_r <= sfr_wdata;
            end
            if (sfr_addr == OFS_DATA_MID) begin
                pointer_data_middle_r <= sfr_wdata;
            end
            if (sfr_addr == OFS_DATA_HIGH) begin
                pointer_data_high_r <= sfr_wdata;
            end
        end
    end

    // Snapshots of the 24-bit quantities, taken on a high-byte read.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            vrms_snap_r <= RST_WORD;
            irms_snap_r <= RST_WORD;
            wav1_snap_r <= RST_WORD;
            wav2_snap_r <= RST_WORD;
        end else if (sfr_rd) begin
            if (sfr_addr == OFS_VRMS_HIGH) begin
                vrms_snap_r <= voltage_rms_bytes;
            end
            if (sfr_addr == OFS_IRMS_HIGH) begin
                irms_snap_r <= current_rms_bytes;
            end
            if (sfr_addr == OFS_WAV1_HIGH) begin
                wav1_snap_r <= waveform_sample_one;
            end
            if (sfr_addr == OFS_WAV2_HIGH) begin
                wav2_snap_r <= waveform_sample_two;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            metering_interrupt_enable <= RST_WORD;
        end else if (sfr_wr) begin
            if (sfr_addr == OFS_IRQ_EN_LOW) begin
                metering_interrupt_enable[7:0] <= sfr_wdata;
            end
            if (sfr_addr == OFS_IRQ_EN_MID) begin
                metering_interrupt_enable[15:8] <= sfr_wdata;
            end
            if (sfr_addr == OFS_IRQ_EN_HIGH) begin
                metering_interrupt_enable[23:16] <= sfr_wdata;
            end
        end
    end

    // Status writes are forwarded; the core decides how they clear its flags.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            irq_status_wr <= 1'b0;
            irq_status_byte <= 2'h0;
            irq_status_wdata <= RST_BYTE;
        end else begin
            irq_status_wr <= sfr_wr && (sfr_addr >= OFS_IRQ_ST_LOW)
                && (sfr_addr <= OFS_IRQ_ST_HIGH);
            if (sfr_wr) begin
                irq_status_byte <= 2'(sfr_addr - OFS_IRQ_ST_LOW);
                irq_status_wdata <= sfr_wdata;
            end
        end
    end

    // Read mux; rms and waveform high bytes and status bytes return the live value being latched.
    // Each status byte is captured alone into the read register when it is read.
    always_comb begin
        case (sfr_addr)
            OFS_POINTER: rdata_nxt = metering_pointer_address_r;
            OFS_DATA_LOW: rdata_nxt = pointer_data_low_r;
            OFS_DATA_MID: rdata_nxt = pointer_data_middle_r;
            OFS_DATA_HIGH: rdata_nxt = pointer_data_high_r;
            OFS_VRMS_LOW: rdata_nxt = vrms_snap_r[7:0];
            OFS_VRMS_MID: rdata_nxt = vrms_snap_r[15:8];
            OFS_VRMS_HIGH: rdata_nxt = voltage_rms_bytes[23:16];
            OFS_IRMS_LOW: rdata_nxt = irms_snap_r[7:0];
            OFS_IRMS_MID: rdata_nxt = irms_snap_r[15:8];
            OFS_IRMS_HIGH: rdata_nxt = current_rms_bytes[23:16];
            OFS_IRQ_EN_LOW: rdata_nxt = metering_interrupt_enable[7:0];
            OFS_IRQ_EN_MID: rdata_nxt = metering_interrupt_enable[15:8];
            OFS_IRQ_EN_HIGH: rdata_nxt = metering_interrupt_enable[23:16];
            OFS_IRQ_ST_LOW: rdata_nxt = irq_status_live[7:0];
            OFS_IRQ_ST_MID: rdata_nxt = irq_status_live[15:8];
            OFS_IRQ_ST_HIGH: rdata_nxt = irq_status_live[23:16];
            OFS_WAV1_LOW: rdata_nxt = wav1_snap_r[7:0];
            OFS_WAV1_MID: rdata_nxt = wav1_snap_r[15:8];
            OFS_WAV1_HIGH: rdata_nxt = waveform_sample_one[23:16];
            OFS_WAV2_LOW: rdata_nxt = wav2_snap_r[7:0];
            OFS_WAV2_MID: rdata_nxt = wav2_snap_r[15:8];
            OFS_WAV2_HIGH: rdata_nxt = waveform_sample_two[23:16];
            default: rdata_nxt = RST_BYTE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sfr_rdata <= RST_BYTE;
        end else if (sfr_rd) begin
            sfr_rdata <= rdata_nxt;
        end
    end
endmodule : mrab_bridge

//--- tb/mrab_bridge_checker.sv
// Concurrent checks on the ports of the metering register access bridge.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/1ps
module mrab_bridge_checker (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_n,
    // Register bus.
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    // Core side.
    input wire logic [23:0] voltage_rms_bytes,
    input wire logic [23:0] irq_status_live,
    input wire logic meter_tick,
    input wire logic [6:0] mreg_addr,
    input wire logic mreg_wr,
    input wire logic mreg_rd,
    input wire logic pointer_busy
);
    import mrab_pkg::*;
    localparam int TICK = METER_TICK_CYCLES;
    logic [7:0] cnt_r;
    logic seen_r;
    logic [7:0] ptr_r;
    logic [23:0] snap_r;
    logic [7:0] snap_mid, vrms_high, irq_mid;
    logic ptr_wr;
    assign ptr_wr = sfr_wr && sfr_addr == OFS_POINTER;
    assign snap_mid = snap_r[15:8];
    assign vrms_high = voltage_rms_bytes[23:16];
    assign irq_mid = irq_status_live[15:8];
    // The counter saturates so a lost tick shows as a count beyond the period.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cnt_r <= 8'h00;
            seen_r <= 1'b0;
        end else if (meter_tick) begin
            cnt_r <= 8'h01;
            seen_r <= 1'b1;
        end else if (cnt_r != 8'hFF) begin
            cnt_r <= cnt_r + 8'h01;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!rst_n) ptr_r <= 8'h00;
        else if (ptr_wr) ptr_r <= sfr_wdata;
    end
    always_ff @(posedge sys_clk) begin
        if (!rst_n) snap_r <= 24'h000000;
        else if (sfr_rd && sfr_addr == OFS_VRMS_HIGH) snap_r <= voltage_rms_bytes;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_tick_period: assert property (seen_r |-> (meter_tick ? cnt_r == TICK : cnt_r < TICK))
        else $error("metering tick period wrong");
    a_ptr_busy: assert property (ptr_wr |=> pointer_busy)
        else $error("pointer write did not raise busy");
    a_busy_release: assert property (pointer_busy && meter_tick && !ptr_wr |=> !pointer_busy)
        else $error("busy held past the tick");
    a_wr_after_tick: assert property (mreg_wr |-> $past(meter_tick) && $past(pointer_busy))
        else $error("core write without pending tick");
    a_wr_single: assert property (mreg_wr |=> !mreg_wr [*2])
        else $error("core write repeated");
    a_wr_addr: assert property (mreg_wr |-> mreg_addr == ptr_r[6:0])
        else $error("core write to wrong address");
    a_rd_after_tick: assert property (mreg_rd |-> $past(meter_tick) && $past(pointer_busy))
        else $error("core read without pending tick");
    a_unmapped_zero: assert property (sfr_rd && sfr_addr < OFS_POINTER |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_high_live: assert property (sfr_rd && sfr_addr == OFS_VRMS_HIGH |=> sfr_rdata == $past(vrms_high))
        else $error("high byte not live");
    a_mid_snapshot: assert property (sfr_rd && sfr_addr == OFS_VRMS_MID |=> sfr_rdata == $past(snap_mid))
        else $error("middle byte not from snapshot");
    a_irq_capture: assert property (sfr_rd && sfr_addr == OFS_IRQ_ST_MID |=> sfr_rdata == $past(irq_mid))
        else $error("status byte not captured");
    c_core_write: cover property (mreg_wr);
    c_busy_fall: cover property (pointer_busy ##1 !pointer_busy);
    c_high_read: cover property (sfr_rd && sfr_addr == OFS_VRMS_HIGH);
endmodule : mrab_bridge_checker

bind mrab_bridge mrab_bridge_checker mrab_bridge_checker_inst (.sys_clk, .rst_n, .sfr_addr,
    .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .voltage_rms_bytes, .irq_status_live,
    .meter_tick, .mreg_addr, .mreg_wr, .mreg_rd, .pointer_busy);

//--- tb/mrab_meter_model.sv
// Behavioural metering core page behind the bridge's indirect port.
// Assumes read data is looked up combinationally from the registered address.
`timescale 1ns/1ps
module mrab_meter_model (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_n,
    // Indirect port.
    input wire logic [6:0] mreg_addr,
    input wire logic mreg_wr,
    input wire logic [23:0] mreg_wdata,
    output logic [23:0] mreg_rdata,
    output logic mreg_one_byte
);
    logic [23:0] mem_r [0:127];
    function automatic logic is_byte(input logic [6:0] a);
        return (a >= 7'h0B && a <= 7'h10) || a == 7'h13;
    endfunction : is_byte
    assign mreg_one_byte = is_byte(mreg_addr);
    // Upper bytes of a one-byte register are junk, so the bridge must clear them.
    // Writes are stored whole, so upper bytes the bridge fails to drop show up here.
    assign mreg_rdata = is_byte(mreg_addr) ? {16'hA5C3, mem_r[mreg_addr][7:0]} : mem_r[mreg_addr];
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < 128; i++) mem_r[i] <= 24'h000000;
        end else if (mreg_wr) begin
            mem_r[mreg_addr] <= mreg_wdata;
        end
    end
endmodule : mrab_meter_model

//--- tb/mrab_bridge_test.sv
// Self-checking bench for the metering register access bridge.
// Drives the register bus on falling edges; a core model sits on the indirect port.
`timescale 1ns/1ps
module mrab_bridge_test;
    import mrab_pkg::*;
    logic sys_clk = 1'b0, rst_n = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00;
    logic [23:0] voltage_rms_bytes = '0, current_rms_bytes = '0, irq_status_live = '0;
    logic [23:0] waveform_sample_one = '0, waveform_sample_two = '0;
    logic [7:0] sfr_rdata, irq_status_wdata;
    logic [23:0] metering_interrupt_enable, mreg_wdata, mreg_rdata;
    logic irq_status_wr, meter_tick, mreg_wr, mreg_one_byte, pointer_busy;
    logic [1:0] irq_status_byte;
    logic [6:0] mreg_addr;
    int n_errors = 0;
    int checked = 0;
    always #5 sys_clk = ~sys_clk;
    mrab_bridge mrab_bridge_inst (.sys_clk, .rst_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
        .sfr_rdata, .voltage_rms_bytes, .current_rms_bytes, .waveform_sample_one,
        .waveform_sample_two, .irq_status_live, .metering_interrupt_enable, .irq_status_wr,
        .irq_status_byte, .irq_status_wdata, .meter_tick, .mreg_addr, .mreg_wr, .mreg_rd(),
        .mreg_wdata, .mreg_rdata, .mreg_one_byte, .pointer_busy);
    mrab_meter_model mrab_meter_model_inst (.sys_clk, .rst_n, .mreg_addr, .mreg_wr,
        .mreg_wdata, .mreg_rdata, .mreg_one_byte);
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    // Each access leaves one idle cycle so no strobe is set twice in a time step.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge sys_clk);
        sfr_wr = 1'b0;
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(negedge sys_clk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge sys_clk);
        sfr_rd = 1'b0;
        chk({16'h0000, sfr_rdata}, {16'h0000, e});
    endtask : rd_chk
    task automatic wait_idle();
        int i;
        for (i = 0; i < 300 && pointer_busy !== 1'b0; i++) @(negedge sys_clk);
        if (i == 300) begin
            n_errors++;
            $display("CHECK FAILED at %0t: pointer stays busy", $time);
            report_and_stop();
        end else begin
            repeat (3) @(negedge sys_clk);
        end
    endtask : wait_idle
    task automatic t_direct();
        logic [23:0] v [4];
        logic [7:0] h [4];
        v = '{24'hA1B2C3, 24'hD4E5F6, 24'h172839, 24'h4A5B6C};
        h = '{OFS_VRMS_HIGH, OFS_IRMS_HIGH, OFS_WAV1_HIGH, OFS_WAV2_HIGH};
        rd_chk(OFS_VRMS_LOW, 8'h00);
        {voltage_rms_bytes, current_rms_bytes} = {v[0], v[1]};
        {waveform_sample_one, waveform_sample_two} = {v[2], v[3]};
        for (int k = 0; k < 4; k++) rd_chk(h[k], v[k][23:16]);
        {voltage_rms_bytes, current_rms_bytes} = {~v[0], ~v[1]};
        {waveform_sample_one, waveform_sample_two} = {~v[2], ~v[3]};
        for (int k = 0; k < 4; k++) begin
            rd_chk(h[k] - 8'h01, v[k][15:8]);
            rd_chk(h[k] - 8'h02, v[k][7:0]);
        end
        rd_chk(8'h50, 8'h00);
    endtask : t_direct
    task automatic t_irq();
        chk(metering_interrupt_enable, 24'h000000);
        irq_status_live = 24'h445566;
        rd_chk(OFS_IRQ_ST_MID, 8'h55);
        irq_status_live = 24'h778899;
        rd_chk(OFS_IRQ_ST_LOW, 8'h99);
        wr(OFS_IRQ_EN_MID, 8'h5A);
        chk(metering_interrupt_enable, 24'h005A00);
        rd_chk(OFS_IRQ_EN_MID, 8'h5A);
        wr(OFS_IRQ_ST_HIGH, 8'h0F);
        chk({13'h0000, irq_status_wr, irq_status_byte, irq_status_wdata}, 24'h00060F);
    endtask : t_irq
    task automatic t_indirect();
        rd_chk(OFS_DATA_LOW, 8'h00);
        wr(OFS_DATA_LOW, 8'h33);
        wr(OFS_DATA_MID, 8'h22);
        wr(OFS_DATA_HIGH, 8'h11);
        wr(OFS_POINTER, 8'hA0);
        chk({23'h0, pointer_busy}, 24'h000001);
        wait_idle();
        chk(mrab_meter_model_inst.mem_r[7'h20], 24'h112233);
        wr(OFS_DATA_LOW, 8'h6E);
        wr(OFS_POINTER, 8'h8B);
        wait_idle();
        chk(mrab_meter_model_inst.mem_r[7'h0B], 24'h00006E);
        wr(OFS_DATA_HIGH, 8'hEE);
        wr(OFS_POINTER, 8'h20);
        wait_idle();
        chk(mrab_meter_model_inst.mem_r[7'h20], 24'h112233);
        rd_chk(OFS_DATA_HIGH, 8'h11);
        rd_chk(OFS_DATA_MID, 8'h22);
        rd_chk(OFS_DATA_LOW, 8'h33);
        wr(OFS_POINTER, 8'h0B);
        wait_idle();
        rd_chk(OFS_DATA_LOW, 8'h6E);
        rd_chk(OFS_DATA_MID, 8'h00);
        rd_chk(OFS_DATA_HIGH, 8'h00);
    endtask : t_indirect
    initial begin
        repeat (16) @(negedge sys_clk);
        rst_n = 1'b1;
        t_direct();
        t_irq();
        t_indirect();
        report_and_stop();
    end
endmodule : mrab_bridge_test
